// *** verilog/wdthr_pkg.sv ***
// Purpose: Shared constants and types for the watchdog fail-threshold block
// Assumes: 8-bit registers on a plain strobe port, 11-bit byte address
// Notes: Offsets and reset values are used by the block and the bench
package wdthr_pkg;
    // Register offsets
    localparam logic [10:0] WDTHR_THR_CFG_OFS = 11'h409;
    localparam logic [10:0] WDTHR_FAIL_CNT_OFS = 11'h40a;
    localparam logic [10:0] WDTHR_ENABLE_OFS = 11'h40b;
    localparam logic [10:0] WDTHR_INT_OFS = 11'h40c;
    // Reset values
    localparam logic [7:0] WDTHR_THR_CFG_RST = 8'hff;
    localparam logic [7:0] WDTHR_FAIL_CNT_RST = 8'h20;
    // Threshold configuration field positions
    localparam int WDTHR_RST_EN_BIT = 7;
    localparam int WDTHR_WD_ON_BIT = 6;
    localparam int WDTHR_FIRST_TH_LSB = 3;
    localparam int WDTHR_SECOND_TH_LSB = 0;
    // Status field positions
    localparam int WDTHR_BAD_BIT = 6;
    localparam int WDTHR_FIRST_OK_BIT = 5;
    // Interrupt status positions
    localparam int WDTHR_RST_INT_BIT = 7;
    localparam int WDTHR_FAIL_INT_BIT = 6;
    // Counter limits
    localparam logic [3:0] WDTHR_CNT_MAX = 4'hf;

    // Register bus request
    typedef struct packed {
        logic [10:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } wdthr_bus_t;

    // Sequencer events
    typedef struct packed {
        logic seq_end;
        logic good;
        logic bad;
        logic long_win_entry;
        logic in_long_win;
    } wdthr_evt_t;

    // Counter state
    typedef enum logic [1:0] {
        WDTHR_OK = 2'b00,
        WDTHR_FAILED = 2'b01,
        WDTHR_RESET = 2'b10
    } wdthr_level_t;
endpackage : wdthr_pkg

// *** verilog/wdthr_cmp.sv ***
// Purpose: Compares the fail counter with both thresholds
// Assumes: Thresholds are 3-bit, counter 4-bit
// Notes: Purely combinational
module wdthr_cmp
    import wdthr_pkg::*;
(
    // Operands
    input wire logic [3:0] cnt_i,
    input wire logic [2:0] first_th_i,
    input wire logic [2:0] second_th_i,
    // Result
    output wdthr_level_t level_o
);
    logic [3:0] sum; // First plus second threshold

    // Sum fits in 4 bits, at most 14
    assign sum = {1'b0, first_th_i} + {1'b0, second_th_i};

    // Classify counter against thresholds
    always_comb
    begin
        if (cnt_i > sum)
        begin
            level_o = WDTHR_RESET;
        end
        else if (cnt_i > {1'b0, first_th_i})
        begin
            level_o = WDTHR_FAILED;
        end
        else
        begin
            level_o = WDTHR_OK;
        end
    end
endmodule // wdthr_cmp

// *** verilog/wdthr_failcnt.sv ***
// Purpose: Saturating fail counter, cleared on long-window entry
// Assumes: Events are one-cycle pulses
// Notes: Counts sequences that saw a bad event
module wdthr_failcnt
    import wdthr_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    // Events
    input wire logic clear_i,
    input wire logic step_i,
    // Count
    output logic [3:0] cnt_o
);
    // Counter update, clear has priority
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            cnt_o <= 4'h0;
        end
        else if (ce_i)
        begin
            if (clear_i)
            begin
                cnt_o <= 4'h0;
            end
            else if (step_i && cnt_o != WDTHR_CNT_MAX)
            begin
                cnt_o <= cnt_o + 4'h1;
            end
        end
    end
endmodule // wdthr_failcnt

// *** verilog/wdthr_top.sv ***
// Purpose: Watchdog fail counter, thresholds, driver enable and warm reset
// Assumes: Sequencer supplies one-cycle event pulses and a long-window level
// Notes: Registers on a plain strobe port, read data one cycle later
//        Driver enable and interrupt status sit in two extra registers
//
// Chosen here: the address-and-strobe port.
module wdthr_top
    import wdthr_pkg::*;
(
    // Clock, reset, enable
    input wire logic CLK_I,
    input wire logic RST_N_I,
    input wire logic CE_I,
    // Register port
    input wire logic [10:0] ADDR_I,
    input wire logic [7:0] WDATA_I,
    input wire logic WR_I,
    input wire logic RD_I,
    output logic [7:0] RDATA_O,
    // Sequencer events
    input wire logic SEQ_END_I,
    input wire logic GOOD_EVENT_I,
    input wire logic BAD_EVENT_I,
    input wire logic LONG_WIN_ENTRY_I,
    input wire logic IN_LONG_WIN_I,
    // Other interrupt sources pending
    input wire logic OTHER_INT_PENDING_I,
    // Outputs
    output logic DRIVER_ENABLE_O,
    output logic WARM_RESET_O
);
    wdthr_bus_t bus; // Bundled register request
    wdthr_evt_t evt; // Bundled events
    logic [7:0] thr_cfg; // Threshold configuration
    logic bad_event_flag; // Bad event seen this sequence
    logic first_good_flag; // Good event seen since long window
    logic [3:0] fail_counter; // Fail counter value
    logic driver_enable; // Output driver enable
    logic fail_interrupt_status; // Latched driver clear
    logic reset_interrupt_status; // Latched warm reset
    logic warm_reset; // Registered warm reset pulse
    logic fail_prev; // Failed level last cycle
    wdthr_level_t level; // Counter against thresholds
    logic failed; // Counter above first threshold
    logic reset_cond; // Counter above threshold sum
    logic bad_seq; // Sequence ended with bad event
    logic cnt_clear; // Counter clear request
    logic set_ok; // Driver enable may be set
    logic [7:0] next_rdata; // Read mux output
    logic wr_cfg; // Write to threshold configuration
    logic wr_drv; // Write to driver enable
    logic wr_int; // Write to interrupt status
    logic fail_event; // Counter just passed first threshold
    logic warm_req; // Reset condition with reset enabled

    // Bundle inputs
    assign bus = '{addr: ADDR_I, wdata: WDATA_I, wr: WR_I, rd: RD_I};
    assign evt = '{seq_end: SEQ_END_I, good: GOOD_EVENT_I, bad: BAD_EVENT_I,
                   long_win_entry: LONG_WIN_ENTRY_I, in_long_win: IN_LONG_WIN_I};

    // Address match helper
    function automatic logic hit(input logic [10:0] a, input logic [10:0] ofs);
        hit = (a == ofs);
    endfunction

    // Write decode, one strobe per writable register
    // Only the address is matched here; window and permission gating
    // stay in the owning process so each refusal is visible there
    assign wr_cfg = bus.wr && hit(bus.addr, WDTHR_THR_CFG_OFS);
    assign wr_drv = bus.wr && hit(bus.addr, WDTHR_ENABLE_OFS);
    assign wr_int = bus.wr && hit(bus.addr, WDTHR_INT_OFS);

    // Counter steps when a sequence with a bad event ends
    // A bad event in the closing cycle still belongs to that sequence
    assign bad_seq = evt.seq_end && (bad_event_flag || evt.bad);
    assign cnt_clear = evt.long_win_entry;

    // Fail counter
    // Entry clear has priority over a step in the same cycle
    wdthr_failcnt u_failcnt (
        .clk_i(CLK_I),
        .rst_n_i(RST_N_I),
        .ce_i(CE_I),
        .clear_i(cnt_clear),
        .step_i(bad_seq),
        .cnt_o(fail_counter)
    );

    // Threshold compare
    wdthr_cmp u_cmp (
        .cnt_i(fail_counter),
        .first_th_i(thr_cfg[WDTHR_FIRST_TH_LSB +: 3]),
        .second_th_i(thr_cfg[WDTHR_SECOND_TH_LSB +: 3]),
        .level_o(level)
    );

    // Levels from comparator
    assign failed = (level != WDTHR_OK);
    assign reset_cond = (level == WDTHR_RESET);

    // Fail event: first cycle above the first threshold with the driver
    // still on; a rise with the driver already off is no clear by the
    // watchdog and raises no interrupt
    assign fail_event = failed && !fail_prev && driver_enable;

    // Warm reset request; the enable bit only masks the request, the
    // counter and the compare run regardless
    assign warm_req = reset_cond && thr_cfg[WDTHR_RST_EN_BIT];

    // Conditions to let software set the driver enable
    // Own fail and reset interrupt bits are not counted as other sources
    always_comb
    begin
        // Watchdog on: out of long window, below threshold, good seen
        if (thr_cfg[WDTHR_WD_ON_BIT])
        begin
            set_ok = !evt.in_long_win && !failed && first_good_flag
                     && !OTHER_INT_PENDING_I;
        end
        else
        begin
            // Watchdog off: only other interrupt sources matter
            set_ok = !OTHER_INT_PENDING_I;
        end
    end

    // Threshold configuration, writable only in long window
    // A refused write leaves all four fields as they were
    // New fields take effect in the cycle after the write
    always_ff @(posedge CLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
        begin
            thr_cfg <= WDTHR_THR_CFG_RST;
        end
        else if (CE_I)
        begin
            if (wr_cfg && evt.in_long_win)
            begin
                thr_cfg <= bus.wdata;
            end
        end
    end

    // Bad event flag
    // Sequence end wins over a bad event in the same cycle; that bad
    // event still steps the counter through bad_seq
    always_ff @(posedge CLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
        begin
            bad_event_flag <= WDTHR_FAIL_CNT_RST[WDTHR_BAD_BIT];
        end
        else if (CE_I)
        begin
            if (evt.seq_end)
            begin
                bad_event_flag <= 1'b0;
            end
            else if (evt.bad)
            begin
                bad_event_flag <= 1'b1;
            end
        end
    end

    // First good flag, set wins over clear
    // A good event in the entry cycle keeps the flag set
    always_ff @(posedge CLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
        begin
            first_good_flag <= WDTHR_FAIL_CNT_RST[WDTHR_FIRST_OK_BIT];
        end
        else if (CE_I)
        begin
            if (evt.good)
            begin
                first_good_flag <= 1'b1;
            end
            else if (evt.long_win_entry)
            begin
                first_good_flag <= 1'b0;
            end
        end
    end

    // Failed level history for edge of fail event
    // Starts low; the counter is zero after reset, so no false edge
    always_ff @(posedge CLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
        begin
            fail_prev <= 1'b0;
        end
        else if (CE_I)
        begin
            fail_prev <= failed;
        end
    end

    // Driver enable: hardware clear beats software set
    // A set in the cycle the counter passes the threshold is lost
    always_ff @(posedge CLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
        begin
            driver_enable <= 1'b0;
        end
        else if (CE_I)
        begin
            if (failed)
            begin
                driver_enable <= 1'b0;
            end
            else if (wr_drv)
            begin
                // Clearing always allowed, setting gated
                if (!bus.wdata[0])
                begin
                    driver_enable <= 1'b0;
                end
                else if (set_ok)
                begin
                    driver_enable <= 1'b1;
                end
            end
        end
    end

    // Warm reset pulse when enabled
    // Repeats every other cycle while the condition holds; only a
    // long-window entry clears the counter and ends the repeats
    always_ff @(posedge CLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
        begin
            warm_reset <= 1'b0;
        end
        else if (CE_I)
        begin
            warm_reset <= warm_req && !warm_reset;
        end
    end

    // Fail interrupt status, set wins over write-one clear
    // Writing zero to the bit leaves it as it is
    always_ff @(posedge CLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
        begin
            fail_interrupt_status <= 1'b0;
        end
        else if (CE_I)
        begin
            if (fail_event)
            begin
                fail_interrupt_status <= 1'b1;
            end
            else if (wr_int && bus.wdata[WDTHR_FAIL_INT_BIT])
            begin
                fail_interrupt_status <= 1'b0;
            end
        end
    end

    // Reset interrupt status, set wins over write-one clear
    // Every repeated warm reset pulse sets it again
    always_ff @(posedge CLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
        begin
            reset_interrupt_status <= 1'b0;
        end
        else if (CE_I)
        begin
            if (warm_reset)
            begin
                reset_interrupt_status <= 1'b1;
            end
            else if (wr_int && bus.wdata[WDTHR_RST_INT_BIT])
            begin
                reset_interrupt_status <= 1'b0;
            end
        end
    end

    // Read mux
    // Unmapped offsets and unused bits read zero
    always_comb
    begin
        next_rdata = 8'h00;
        if (hit(bus.addr, WDTHR_THR_CFG_OFS))
        begin
            next_rdata = thr_cfg;
        end
        else if (hit(bus.addr, WDTHR_FAIL_CNT_OFS))
        begin
            // Reserved bits 7 and 4 stay at zero
            next_rdata[WDTHR_BAD_BIT] = bad_event_flag;
            next_rdata[WDTHR_FIRST_OK_BIT] = first_good_flag;
            next_rdata[3:0] = fail_counter;
        end
        else if (hit(bus.addr, WDTHR_ENABLE_OFS))
        begin
            next_rdata = {7'h00, driver_enable};
        end
        else if (hit(bus.addr, WDTHR_INT_OFS))
        begin
            next_rdata[WDTHR_RST_INT_BIT] = reset_interrupt_status;
            next_rdata[WDTHR_FAIL_INT_BIT] = fail_interrupt_status;
        end
    end

    // Read data register, zero when no read
    // Zero between reads so no stale value is taken twice
    always_ff @(posedge CLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
        begin
            RDATA_O <= 8'h00;
        end
        else if (CE_I)
        begin
            RDATA_O <= bus.rd ? next_rdata : 8'h00;
        end
    end

    // Outputs
    // Both come straight from flip-flops
    assign DRIVER_ENABLE_O = driver_enable;
    assign WARM_RESET_O = warm_reset;
endmodule // wdthr_top

// *** verification/wdthr_properties.sv ***
// Purpose: Port-level assertions for the watchdog threshold block
// Assumes: One clock, active-low asynchronous reset
// Notes: Bound to wdthr_top below the module
module wdthr_properties
    import wdthr_pkg::*;
(
    // Clock, reset, enable
    input wire logic CLK_I,
    input wire logic RST_N_I,
    input wire logic CE_I,
    // Register port
    input wire logic [10:0] ADDR_I,
    input wire logic [7:0] WDATA_I,
    input wire logic WR_I,
    input wire logic RD_I,
    input wire logic [7:0] RDATA_O,
    // Sequencer events
    input wire logic SEQ_END_I,
    input wire logic GOOD_EVENT_I,
    input wire logic BAD_EVENT_I,
    input wire logic LONG_WIN_ENTRY_I,
    input wire logic IN_LONG_WIN_I,
    input wire logic OTHER_INT_PENDING_I,
    // Outputs
    input wire logic DRIVER_ENABLE_O,
    input wire logic WARM_RESET_O
);
    default clocking @(posedge CLK_I); endclocking
    default disable iff (!RST_N_I);
    // Read of the status register taken this cycle
    wire logic st_rd = RD_I && CE_I && ADDR_I == WDTHR_FAIL_CNT_OFS;

    status_rsvd_a: assert property (st_rd |=> !RDATA_O[7] && !RDATA_O[4])
        else $error("Reserved status bits not zero");
    unmapped_zero_a: assert property (RD_I && CE_I && ADDR_I < WDTHR_THR_CFG_OFS
        |=> RDATA_O == 8'h00) else $error("Unmapped read not zero");
    warm_pulse_a: assert property (WARM_RESET_O && CE_I |=> !WARM_RESET_O)
        else $error("Warm reset longer than one cycle");
    drv_cause_a: assert property ($rose(DRIVER_ENABLE_O)
        |-> $past(WR_I && CE_I && ADDR_I == WDTHR_ENABLE_OFS && WDATA_I[0]))
        else $error("Driver enable rose without a write");
    drv_other_a: assert property ($rose(DRIVER_ENABLE_O) |-> !$past(OTHER_INT_PENDING_I))
        else $error("Driver enable set with other interrupt pending");
    entry_nowarm_a: assert property (LONG_WIN_ENTRY_I && CE_I ##1 CE_I
        |=> !WARM_RESET_O) else $error("Warm reset after counter cleared");
    bad_flag_a: assert property (BAD_EVENT_I && !SEQ_END_I && CE_I ##1 st_rd
        |=> RDATA_O[6]) else $error("Bad flag not set");
    good_flag_a: assert property (GOOD_EVENT_I && CE_I ##1 st_rd |=> RDATA_O[5])
        else $error("First good flag not set");
    entry_clear_a: assert property (LONG_WIN_ENTRY_I && !GOOD_EVENT_I && CE_I ##1 st_rd
        |=> RDATA_O[5:0] == 6'h00) else $error("Entry did not clear status");
endmodule // wdthr_properties

bind wdthr_top wdthr_properties u_props (.CLK_I(CLK_I), .RST_N_I(RST_N_I), .CE_I(CE_I),
    .ADDR_I(ADDR_I), .WDATA_I(WDATA_I), .WR_I(WR_I), .RD_I(RD_I), .RDATA_O(RDATA_O),
    .SEQ_END_I(SEQ_END_I), .GOOD_EVENT_I(GOOD_EVENT_I), .BAD_EVENT_I(BAD_EVENT_I),
    .LONG_WIN_ENTRY_I(LONG_WIN_ENTRY_I), .IN_LONG_WIN_I(IN_LONG_WIN_I),
    .OTHER_INT_PENDING_I(OTHER_INT_PENDING_I), .DRIVER_ENABLE_O(DRIVER_ENABLE_O),
    .WARM_RESET_O(WARM_RESET_O));

// *** verification/test_wdthr_top.sv ***
// Purpose: Self-checking bench for the watchdog threshold block
// Assumes: CE_I high except around one frozen write per phase, events are one-cycle pulses
// Notes: Thresholds drawn at random from a fixed seed
module test_wdthr_top
    import wdthr_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [10:0] addr = 11'h000;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [3:0] evt = 4'h0; // Seq end, good, bad, entry
    logic in_lw = 1'b0;
    logic other = 1'b0;
    logic ce = 1'b1; // Clock enable
    logic [7:0] rdata;
    logic drv;
    logic warm;
    int mismatches = 0;
    int check_count = 0;
    int warm_seen = 0;
    logic [3:0] cnt; // Expected fail count
    logic [2:0] f;
    logic [2:0] s;
    logic rst_en;
    logic fg; // Expected first-good flag
    logic d_exp; // Expected driver enable

    wdthr_top DUT (.CLK_I(clk), .RST_N_I(rst_n), .CE_I(ce), .ADDR_I(addr),
        .WDATA_I(wdata), .WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .SEQ_END_I(evt[3]),
        .GOOD_EVENT_I(evt[2]), .BAD_EVENT_I(evt[1]), .LONG_WIN_ENTRY_I(evt[0]),
        .IN_LONG_WIN_I(in_lw), .OTHER_INT_PENDING_I(other), .DRIVER_ENABLE_O(drv),
        .WARM_RESET_O(warm));

    // Clock and warm reset monitor
    always #5 clk = ~clk;
    always @(posedge clk) if (warm === 1'b1) warm_seen++;

    // Expected status byte
    function automatic logic [7:0] st(input logic b);
        return {1'b0, b, fg, 1'b0, cnt};
    endfunction

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp)
        begin
            mismatches++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Bus cycles, entered and left at a rising edge
    task automatic wr_reg(input logic [10:0] a, input logic [7:0] d);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
        @(posedge clk);
    endtask

    task automatic rd_reg(input logic [10:0] a, input logic [7:0] exp);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        chk(rdata, exp);
        @(posedge clk);
    endtask

    task automatic ev(input logic [3:0] e);
        evt <= e;
        @(posedge clk);
        evt <= 4'h0;
    endtask

    // One watchdog sequence, with or without a bad event
    task automatic one_seq(input logic bad);
        warm_seen = 0;
        if (bad)
        begin
            ev(4'h2);
            rd_reg(WDTHR_FAIL_CNT_OFS, st(1'b1));
        end
        ev(4'h8);
        if (bad && cnt != WDTHR_CNT_MAX) cnt = cnt + 4'h1;
        d_exp = d_exp && !(cnt > {1'b0, f});
        rd_reg(WDTHR_FAIL_CNT_OFS, st(1'b0));
        @(posedge clk);
        chk({7'h00, drv}, {7'h00, d_exp});
        chk(8'(warm_seen != 0), 8'(rst_en && cnt > {1'b0, f} + {1'b0, s}));
    endtask

    // Configure in long window, then run sequences to saturation
    task automatic phase(input logic re, input logic on);
        in_lw <= 1'b1;
        f = 3'($urandom);
        s = 3'($urandom);
        rst_en = re;
        wr_reg(WDTHR_THR_CFG_OFS, {re, on, f, s});
        // Write with the clock enable low must leave the fields alone
        ce <= 1'b0;
        wr_reg(WDTHR_THR_CFG_OFS, ~{re, on, f, s});
        ce <= 1'b1;
        rd_reg(WDTHR_THR_CFG_OFS, {re, on, f, s});
        ev(4'h1);
        cnt = 4'h0;
        fg = 1'b0;
        rd_reg(WDTHR_FAIL_CNT_OFS, st(1'b0));
        other <= 1'b1;
        wr_reg(WDTHR_ENABLE_OFS, 8'h01);
        chk({7'h00, drv}, 8'h00);
        other <= 1'b0;
        wr_reg(WDTHR_ENABLE_OFS, 8'h01);
        chk({7'h00, drv}, {7'h00, !on});
        in_lw <= 1'b0;
        ev(4'h4);
        fg = 1'b1;
        rd_reg(WDTHR_FAIL_CNT_OFS, st(1'b0));
        wr_reg(WDTHR_ENABLE_OFS, 8'h01);
        d_exp = 1'b1;
        chk({7'h00, drv}, 8'h01);
        for (int i = 0; i < 60 && cnt != WDTHR_CNT_MAX; i++) one_seq(($urandom % 4) != 0);
        one_seq(1'b1);
        rd_reg(WDTHR_INT_OFS, {re, 7'h40});
        // Entry clears the counter and so ends the repeating warm reset
        in_lw <= 1'b1;
        ev(4'h1);
        // Let the last warm reset pulse drain before the clear
        @(posedge clk);
        wr_reg(WDTHR_INT_OFS, 8'hc0);
        rd_reg(WDTHR_INT_OFS, 8'h00);
    endtask

    task automatic finish_test;
        $display("Checks %0d, mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // Main sequence
    initial
    begin
        void'($urandom(78));
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        rd_reg(WDTHR_THR_CFG_OFS, WDTHR_THR_CFG_RST);
        rd_reg(WDTHR_FAIL_CNT_OFS, WDTHR_FAIL_CNT_RST);
        rd_reg(11'h400, 8'h00);
        wr_reg(WDTHR_FAIL_CNT_OFS, 8'h00);
        rd_reg(WDTHR_FAIL_CNT_OFS, WDTHR_FAIL_CNT_RST);
        wr_reg(WDTHR_THR_CFG_OFS, 8'($urandom));
        rd_reg(WDTHR_THR_CFG_OFS, WDTHR_THR_CFG_RST);
        phase(1'b1, 1'b1);
        phase(1'b0, 1'b0);
        finish_test();
    end

    // Hang guard
    initial
    begin
        #50us;
        mismatches++;
        finish_test();
    end
endmodule // test_wdthr_top
